// file: ard_pkg.sv
// Package for the asynchronous receive dispatch block.
// Holds offset bounds, ack codes, transaction codes and posting limits.
package ard_pkg;

    // Offset range bounds, 48-bit offsets.
    localparam logic [47:0] PHYS_TOP = 48'h0000_FFFF_FFFF;
    localparam logic [47:0] SIDE_FREE_TOP = 48'h0000_FFFF_FFFE;
    localparam logic [47:0] POST_TOP = 48'hFFFE_FFFF_FFFF;
    localparam logic [47:0] CSR_BASE = 48'hFFFF_0000_0000;

    // Acknowledge codes; ACK_BUSY_X is internal and goes out on the bus as ACK_BUSY_A or ACK_BUSY_B.
    localparam logic [3:0] ACK_COMPLETE = 4'h1;
    localparam logic [3:0] ACK_PENDING = 4'h2;
    localparam logic [3:0] ACK_BUSY_A = 4'h5;
    localparam logic [3:0] ACK_BUSY_B = 4'h6;
    localparam logic [3:0] ACK_BUSY_X = 4'h4;
    localparam logic [3:0] ACK_NONE = 4'h0;

    // Transaction codes.
    localparam logic [3:0] TC_WR_QUAD = 4'h0;
    localparam logic [3:0] TC_WR_BLK = 4'h1;
    localparam logic [3:0] TC_RD_QUAD = 4'h4;
    localparam logic [3:0] TC_RD_BLK = 4'h5;
    localparam logic [3:0] TC_LOCK = 4'h9;
    localparam logic [3:0] TC_PHY = 4'hE;
    localparam logic [3:0] TC_RESP_WR = 4'h2;
    localparam logic [3:0] TC_RESP_RDQ = 4'h6;
    localparam logic [3:0] TC_RESP_RDB = 4'h7;
    localparam logic [3:0] TC_RESP_LK = 4'hB;

    // Retry codes in the packet header.
    localparam logic [1:0] RETRY_1 = 2'h1;
    localparam logic [1:0] RETRY_A = 2'h2;
    localparam logic [1:0] RETRY_B = 2'h3;

    // Posted write tracking.
    localparam int POST_SLOTS = 4;
    localparam int POST_IDX_W = 2;

    // Dispatch destinations.
    typedef enum logic [4:0] {
        ARD_DST_NONE = 5'b00001,
        ARD_DST_PHYS = 5'b00010,
        ARD_DST_SELFID = 5'b00100,
        ARD_DST_RESP = 5'b01000,
        ARD_DST_REQ = 5'b10000
    } ard_dst_e;

endpackage

// file: ard_async_receive_dispatch.sv
// Receive-side dispatch: sorts each received packet header, chooses its ack.
// Assumes one header per rx_valid pulse from a link core on ref_clk, and
// that the posted-write engine reports completions and failures by slot.
`timescale 1ns/1ps
module ard_async_receive_dispatch #(
    parameter int SLOTS = ard_pkg::POST_SLOTS
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Received header.
    input wire logic rx_valid,
    input wire logic [3:0] rx_tcode,
    input wire logic [15:0] rx_src_id,
    input wire logic [47:0] rx_offset,
    input wire logic [15:0] rx_ext_tcode,
    input wire logic [1:0] rx_retry,
    // Configuration and status.
    input wire logic selfid_phase,
    input wire logic selfid_enable,
    input wire logic posting_enable,
    input wire logic req_fifo_full,
    input wire logic resp_space,
    input wire logic async_receive_dma_fail,
    input wire logic ctx_run,
    // Posted write engine completions.
    input wire logic post_done,
    input wire logic post_fail,
    input wire logic [1:0] post_slot,
    // Dispatch outputs.
    output logic [4:0] dst,
    output logic dst_valid,
    output logic [3:0] ack_code,
    output logic [31:0] mem_addr,
    output logic post_new,
    output logic [1:0] post_new_slot,
    output logic [1:0] rx_phase_next,
    output logic req_hold,
    // Error reporting and posted write count.
    output logic post_err_event,
    output logic [15:0] err_src_id,
    output logic [47:0] err_offset,
    output logic [2:0] pending_count
);

    logic [SLOTS-1:0] busy_reg;
    logic [15:0] src_reg [SLOTS];
    logic [47:0] off_reg [SLOTS];
    logic dead_reg;
    logic async_posted_reg;
    logic [1:0] phase_reg;

    logic is_req, is_write, is_read, is_lock, ext_nz, is_phys, is_high;
    logic in_post_rng, free_slot, can_post, busy_it;
    logic [1:0] free_idx;
    ard_pkg::ard_dst_e dst_c;
    logic [3:0] ack_c;
    logic post_c;

    // Header classification.
    assign is_write = rx_tcode == ard_pkg::TC_WR_QUAD ||
                      rx_tcode == ard_pkg::TC_WR_BLK;
    assign is_read = rx_tcode == ard_pkg::TC_RD_QUAD ||
                     rx_tcode == ard_pkg::TC_RD_BLK;
    assign is_lock = rx_tcode == ard_pkg::TC_LOCK;
    assign is_req = is_write || is_read || is_lock;
    assign ext_nz = rx_tcode == ard_pkg::TC_WR_BLK && rx_ext_tcode != 16'h0000;
    assign is_phys = rx_offset <= ard_pkg::PHYS_TOP;
    assign is_high = rx_offset >= ard_pkg::CSR_BASE;
    assign in_post_rng = rx_offset >= ard_pkg::PHYS_TOP &&
                         rx_offset <= ard_pkg::POST_TOP;

    // Lowest free tracking slot.
    always_comb begin
        free_slot = 1'b0;
        free_idx = 2'd0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (!busy_reg[i]) begin
                free_slot = 1'b1;
                free_idx = 2'(i);
            end
        end
    end

    // A physical write may be posted only with posting on and a slot free.
    assign can_post = posting_enable && free_slot;
    // A full FIFO or a failed DMA path busies requests for the queue.
    assign busy_it = req_fifo_full || dead_reg;

    // Dispatch and ack selection.
    always_comb begin
        dst_c = ard_pkg::ARD_DST_NONE;
        ack_c = ard_pkg::ACK_NONE;
        post_c = 1'b0;
        if (rx_tcode == ard_pkg::TC_PHY) begin
            if (selfid_phase) begin
                dst_c = selfid_enable ? ard_pkg::ARD_DST_SELFID
                                      : ard_pkg::ARD_DST_NONE;
            end else if (busy_it) begin
                ack_c = ard_pkg::ACK_BUSY_X;
            end else begin
                dst_c = ard_pkg::ARD_DST_REQ;
                ack_c = ard_pkg::ACK_COMPLETE;
            end
        end else if (rx_tcode == ard_pkg::TC_RESP_WR ||
                     rx_tcode == ard_pkg::TC_RESP_RDQ ||
                     rx_tcode == ard_pkg::TC_RESP_RDB ||
                     rx_tcode == ard_pkg::TC_RESP_LK) begin
            // Without room the response is dropped; the requester times out.
            if (resp_space) begin
                dst_c = ard_pkg::ARD_DST_RESP;
                ack_c = ard_pkg::ACK_COMPLETE;
            end
        end else if (is_req && is_phys && !is_lock && !ext_nz) begin
            // Physical unit runs beside the request path.
            dst_c = ard_pkg::ARD_DST_PHYS;
            if (is_write && can_post) begin
                ack_c = ard_pkg::ACK_COMPLETE;
                post_c = 1'b1;
            end else begin
                ack_c = ard_pkg::ACK_PENDING;
            end
        end else if (is_req) begin
            if (busy_it) begin
                ack_c = ard_pkg::ACK_BUSY_X;
            end else if (is_high || ext_nz) begin
                ack_c = ard_pkg::ACK_PENDING;
                dst_c = ard_pkg::ARD_DST_REQ;
            end else if (is_write && in_post_rng) begin
                ack_c = ard_pkg::ACK_COMPLETE;
                dst_c = ard_pkg::ARD_DST_REQ;
            end else begin
                ack_c = ard_pkg::ACK_PENDING;
                dst_c = ard_pkg::ARD_DST_REQ;
            end
        end
        // Busy acks take the dual-phase code in hardware.
        if (ack_c == ard_pkg::ACK_BUSY_X) begin
            ack_c = phase_reg[0] ? ard_pkg::ACK_BUSY_B : ard_pkg::ACK_BUSY_A;
        end
    end

    // Dual-phase retry phase: toggles on each busied packet whose retry code is not RETRY_1.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= 2'd0;
        end else if (rx_valid && (ack_c == ard_pkg::ACK_BUSY_A ||
                     ack_c == ard_pkg::ACK_BUSY_B) &&
                     rx_retry != ard_pkg::RETRY_1) begin
            phase_reg <= {1'b0, ~phase_reg[0]};
        end
    end

    // Fail latch: stays set until software stops the context.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dead_reg <= 1'b0;
        end else if (async_receive_dma_fail) begin
            dead_reg <= 1'b1;
        end else if (!ctx_run) begin
            dead_reg <= 1'b0;
        end
    end

    // Posted write slots; a new post wins over a completion on one slot.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_reg <= '0;
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                if (rx_valid && post_c && free_idx == 2'(i)) begin
                    busy_reg[i] <= 1'b1;
                end else if ((post_done || post_fail) &&
                             post_slot == 2'(i)) begin
                    busy_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Per-slot capture of requester and offset.
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < SLOTS; i++) begin
            if (rst) begin
                src_reg[i] <= 16'h0000;
                off_reg[i] <= 48'h0000_0000_0000;
            end else if (rx_valid && post_c && free_idx == 2'(i)) begin
                src_reg[i] <= rx_src_id;
                off_reg[i] <= rx_offset;
            end
        end
    end

    // Failure report.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            post_err_event <= 1'b0;
            err_src_id <= 16'h0000;
            err_offset <= 48'h0000_0000_0000;
        end else begin
            post_err_event <= post_fail && busy_reg[post_slot];
            if (post_fail && busy_reg[post_slot]) begin
                err_src_id <= src_reg[post_slot];
                err_offset <= off_reg[post_slot];
            end
        end
    end

    // Async writes in the posting range count as posted until drained.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            async_posted_reg <= 1'b0;
        end else if (rx_valid && dst_c == ard_pkg::ARD_DST_REQ && is_write &&
                     ack_c == ard_pkg::ACK_COMPLETE) begin
            async_posted_reg <= 1'b1;
        end else if (!req_fifo_full && busy_reg == '0) begin
            async_posted_reg <= 1'b0;
        end
    end

    // Queue hold: request queue waits for every posted write.
    // A dead context still drains, but its entries are dropped.
    assign req_hold = !dead_reg && (busy_reg != '0 || async_posted_reg);

    // Registered dispatch outputs.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dst <= ard_pkg::ARD_DST_NONE;
            dst_valid <= 1'b0;
            ack_code <= ard_pkg::ACK_NONE;
            mem_addr <= 32'h0000_0000;
            post_new <= 1'b0;
            post_new_slot <= 2'd0;
        end else begin
            dst <= dst_c;
            dst_valid <= rx_valid && dst_c != ard_pkg::ARD_DST_NONE;
            ack_code <= rx_valid ? ack_c : ard_pkg::ACK_NONE;
            // Direct offset use keeps low-range access in its region.
            mem_addr <= rx_offset[31:0];
            // Physical posts issue in arrival order.
            post_new <= rx_valid && post_c;
            post_new_slot <= free_idx;
        end
    end

    assign rx_phase_next = phase_reg;

    // Count of outstanding posted writes.
    always_comb begin
        pending_count = 3'd0;
        for (int i = 0; i < SLOTS; i++) begin
            pending_count = pending_count + 3'(busy_reg[i]);
        end
    end

    a_post_cap: assert property (@(posedge ref_clk) disable iff (rst)
        (busy_reg == '1 && rx_valid) |=> !post_new)
        else $error("post beyond slot limit");
    a_busy_full: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_valid && req_fifo_full && is_req && !is_phys) |=>
        (ack_code == ard_pkg::ACK_BUSY_A || ack_code == ard_pkg::ACK_BUSY_B))
        else $error("full fifo not busied");
    a_high_pend: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_valid && is_req && is_high && !busy_it) |=>
        ack_code == ard_pkg::ACK_PENDING)
        else $error("high offset not pending");
    a_no_post_off: assert property (@(posedge ref_clk) disable iff (rst)
        !posting_enable |=> !post_new)
        else $error("posted while disabled");
    a_selfid_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_valid && !selfid_phase) |=> dst != ard_pkg::ARD_DST_SELFID)
        else $error("selfid outside phase");
    a_dead_busy: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(dead_reg) |-> !req_hold)
        else $error("dead context holds queue");
    a_err_event: assert property (@(posedge ref_clk) disable iff (rst)
        (post_fail && busy_reg[post_slot]) |=> post_err_event)
        else $error("posted failure not reported");
    a_resp_drop: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_valid && rx_tcode == ard_pkg::TC_RESP_WR && !resp_space) |=>
        !dst_valid)
        else $error("response kept without space");

endmodule

// file: ard_remote_node.sv
// Remote bus node model that hands received headers to the dispatch block.
// Assumes the bench calls send at a falling edge of ref_clk.
`timescale 1ns/1ps
module ard_remote_node (
    // Clock.
    input wire logic ref_clk,
    // Header towards the dispatch block.
    output logic rx_valid,
    output logic [3:0] rx_tcode,
    output logic [15:0] rx_src_id,
    output logic [47:0] rx_offset,
    output logic [15:0] rx_ext_tcode,
    output logic [1:0] rx_retry
);
    // Idle lines start at a fixed pattern before the first header.
    initial begin
        rx_valid = 1'b0;
        rx_tcode = 4'h0;
        rx_src_id = 16'h0000;
        rx_offset = 48'h0000_0000_0000;
        rx_ext_tcode = 16'h0000;
        rx_retry = 2'h0;
    end

    // One header for one cycle; afterwards the fields show their inverse,
    // so stale data can never pass for a fresh header.
    task automatic send(input logic [3:0] tc, input logic [15:0] src,
        input logic [47:0] off, input logic [15:0] ext);
        rx_tcode = tc;
        rx_src_id = src;
        rx_offset = off;
        rx_ext_tcode = ext;
        rx_retry = ard_pkg::RETRY_A; // Sender asks for dual phase
        rx_valid = 1'b1;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_tcode = ~tc;
        rx_src_id = ~src;
        rx_offset = ~off;
        rx_ext_tcode = ~ext;
        rx_retry = ~ard_pkg::RETRY_A;
    endtask
endmodule

// file: async_receive_dispatch_tb_top.sv
// Self-checking bench for the receive dispatch block.
// Assumes the dispatch block and the remote node model are compiled first.
`timescale 1ns/1ps
module async_receive_dispatch_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic selfid_phase = 1'b0, selfid_enable = 1'b1, posting_enable = 1'b0;
    logic req_fifo_full = 1'b0, resp_space = 1'b1, ctx_run = 1'b1;
    logic async_receive_dma_fail = 1'b0, post_done = 1'b0, post_fail = 1'b0;
    logic [1:0] post_slot = 2'h0;
    logic rx_valid, dst_valid, post_new, req_hold, post_err_event;
    logic [3:0] rx_tcode, ack_code;
    logic [15:0] rx_src_id, rx_ext_tcode, err_src_id, last_src;
    logic [47:0] rx_offset, err_offset, o;
    logic [1:0] rx_retry, post_new_slot, rx_phase_next;
    logic [4:0] dst;
    logic [31:0] mem_addr;
    logic [2:0] pending_count;
    logic ph = 1'b0;
    logic [15:0] s_src [4];
    logic [47:0] s_off [4];
    int failures = 0;
    int samples_checked = 0;

    // Clock at 40 MHz.
    always #12.5 ref_clk = ~ref_clk;

    ard_remote_node node (.ref_clk(ref_clk), .rx_valid(rx_valid),
        .rx_tcode(rx_tcode), .rx_src_id(rx_src_id), .rx_offset(rx_offset),
        .rx_ext_tcode(rx_ext_tcode), .rx_retry(rx_retry));

    ard_async_receive_dispatch DUT (.ref_clk(ref_clk), .rst(rst),
        .rx_valid(rx_valid), .rx_tcode(rx_tcode), .rx_src_id(rx_src_id),
        .rx_offset(rx_offset), .rx_ext_tcode(rx_ext_tcode),
        .rx_retry(rx_retry), .selfid_phase(selfid_phase),
        .selfid_enable(selfid_enable), .posting_enable(posting_enable),
        .req_fifo_full(req_fifo_full), .resp_space(resp_space),
        .async_receive_dma_fail(async_receive_dma_fail), .ctx_run(ctx_run),
        .post_done(post_done), .post_fail(post_fail), .post_slot(post_slot),
        .dst(dst), .dst_valid(dst_valid), .ack_code(ack_code),
        .mem_addr(mem_addr), .post_new(post_new),
        .post_new_slot(post_new_slot), .rx_phase_next(rx_phase_next),
        .req_hold(req_hold),
        .post_err_event(post_err_event), .err_src_id(err_src_id),
        .err_offset(err_offset), .pending_count(pending_count));

    // Compares one observed value with the model's value.
    task automatic chk(input string nm, input logic [47:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Sends a header and checks the answer one cycle later. A zero edst
    // skips the route; eack F skips the ack, E means anything but complete;
    // epn bit 3 skips the post check, else bit 2 is post_new and 1:0 the slot.
    task automatic hdr(input logic [3:0] tc, input logic [47:0] off,
        input logic [15:0] ext, input logic [4:0] edst, input logic [3:0] eack,
        input logic [3:0] epn);
        last_src = 16'($urandom);
        node.send(tc, last_src, off, ext);
        if (edst == ard_pkg::ARD_DST_NONE) chk("drop", dst_valid, 0);
        else if (edst != 5'h0) chk("dst", {dst_valid, dst}, {1'b1, edst});
        if (edst == ard_pkg::ARD_DST_PHYS) chk("addr", mem_addr, off[31:0]);
        if (eack == ard_pkg::ACK_BUSY_X) begin
            chk("busy", ack_code, ph ? ard_pkg::ACK_BUSY_B : ard_pkg::ACK_BUSY_A);
            ph = ~ph;
            chk("phase", rx_phase_next, {1'b0, ph});
        end else if (eack == 4'hE) chk("nocomp", ack_code === 4'h1, 0);
        else if (eack != 4'hF) chk("ack", ack_code, eack);
        if (!epn[3]) chk("post", {post_new, post_new_slot}, epn[2:0]);
        @(negedge ref_clk);
    endtask

    // Reports a posted write as finished or failed by slot.
    task automatic pst(input logic fl, input logic [1:0] s);
        post_fail = fl;
        post_done = ~fl;
        post_slot = s;
        @(negedge ref_clk);
        post_fail = 1'b0;
        post_done = 1'b0;
        if (fl) chk("err", {post_err_event, err_src_id, err_offset}, {1'b1, s_src[s], s_off[s]});
        @(negedge ref_clk);
    endtask

    // Synchronous reset held for twenty cycles; the model restarts too.
    task automatic do_reset();
        rst = 1'b1;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        ph = 1'b0;
    endtask

    // The single place where the run ends.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #500000;
        failures++;
        end_sim();
    end

    // Main sequence; inputs change on falling edges only.
    initial begin
        @(negedge ref_clk);
        do_reset();
        chk("rst", {dst, ack_code, pending_count}, {5'h01, 4'h0, 3'h0});
        void'($urandom(32'h88fc));
        o = {16'h0000, $urandom};
        selfid_phase = 1'b1;
        hdr(4'hE, o, 0, ard_pkg::ARD_DST_SELFID, 4'hF, 4'h8);
        selfid_phase = 1'b0;
        hdr(4'hE, o, 0, ard_pkg::ARD_DST_REQ, 4'hF, 4'h8);
        hdr(4'h2, o, 0, ard_pkg::ARD_DST_RESP, 4'hF, 4'h8);
        resp_space = 1'b0;
        hdr(4'h2, o, 0, ard_pkg::ARD_DST_NONE, 4'h0, 4'h8);
        resp_space = 1'b1;
        hdr(4'h4, o, 0, ard_pkg::ARD_DST_PHYS, 4'hF, 4'h0);
        hdr(4'h9, o, 0, ard_pkg::ARD_DST_REQ, 4'hF, 4'h0);
        hdr(4'h0, ard_pkg::POST_TOP, 0, ard_pkg::ARD_DST_REQ, 4'h1, 4'h8);
        hdr(4'h0, ard_pkg::CSR_BASE, 0, ard_pkg::ARD_DST_REQ, 4'h2, 4'h8);
        hdr(4'h1, 48'h0001_0000_0000, 1, 5'h0, 4'h2, 4'h8);
        hdr(4'h0, o, 0, ard_pkg::ARD_DST_PHYS, 4'hE, 4'h0);
        $display("dispatch test done");
        do_reset();
        posting_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            s_off[i] = {16'h0000, $urandom};
            hdr(4'h0, s_off[i], 0, ard_pkg::ARD_DST_PHYS, 4'h1, {2'b01, 2'(i)});
            s_src[i] = last_src;
        end
        chk("full", {req_hold, pending_count}, {1'b1, 3'h4});
        hdr(4'h0, o, 0, 5'h0, 4'hE, 4'h0);
        hdr(4'h4, ard_pkg::CSR_BASE, 0, 5'h0, 4'h2, 4'h0);
        pst(1'b1, 2'h2);
        chk("cnt", pending_count, 3);
        pst(1'b0, 2'h0);
        pst(1'b0, 2'h1);
        pst(1'b0, 2'h3);
        chk("idle", {req_hold, pending_count}, {1'b0, 3'h0});
        $display("posting test done");
        do_reset();
        req_fifo_full = 1'b1;
        hdr(4'h0, ard_pkg::POST_TOP, 0, 5'h0, ard_pkg::ACK_BUSY_X, 4'h8);
        hdr(4'h0, ard_pkg::POST_TOP, 0, 5'h0, ard_pkg::ACK_BUSY_X, 4'h8);
        hdr(4'h4, o, 0, ard_pkg::ARD_DST_PHYS, 4'hF, 4'h0);
        req_fifo_full = 1'b0;
        async_receive_dma_fail = 1'b1;
        @(negedge ref_clk);
        async_receive_dma_fail = 1'b0;
        hdr(4'h0, ard_pkg::POST_TOP, 0, 5'h0, ard_pkg::ACK_BUSY_X, 4'h8);
        ctx_run = 1'b0;
        @(negedge ref_clk);
        ctx_run = 1'b1;
        hdr(4'h0, ard_pkg::POST_TOP, 0, ard_pkg::ARD_DST_REQ, 4'h1, 4'h8);
        $display("busy test done");
        end_sim();
    end
endmodule
